// File: tcpw_defines.vh
/*
  Shared constants of the cascadable timer / PWM / event counter block:
  register offsets, control field positions, mode and source-clock codes,
  reset values and timing counts.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef TCPW_DEFINES_VH
`define TCPW_DEFINES_VH

// ==========================================================================
// Register byte offsets on the AHB-Lite slave (low address byte).
`define TCPW_OFS_CTRL3 8'h00
`define TCPW_OFS_CTRL4 8'h04
`define TCPW_OFS_PER_LO 8'h08
`define TCPW_OFS_PER_HI 8'h0c
`define TCPW_OFS_DUTY3 8'h10
`define TCPW_OFS_DUTY4 8'h14
`define TCPW_OFS_STATUS 8'h18

// ==========================================================================
// Control register fields.
`define TCPW_MODE_MSB 1
`define TCPW_MODE_LSB 0
`define TCPW_RUN_BIT 3
`define TCPW_SRC_MSB 6
`define TCPW_SRC_LSB 4
`define TCPW_FFI_BIT 7
`define TCPW_CTRL_RST 8'h00
`define TCPW_BYTE_RST 8'h00

// Operating modes.
`define TCPW_MODE_OFF 2'h0
`define TCPW_MODE_PWM8 2'h1
`define TCPW_MODE_TMR16 2'h2
`define TCPW_MODE_EVT16 2'h3

// Source clock select codes and the prescaler masks that make their ticks.
`define TCPW_SRC_DIV1 3'h0
`define TCPW_SRC_DIV2 3'h1
`define TCPW_SRC_DIV8 3'h2
`define TCPW_SRC_DIV32 3'h3
`define TCPW_SRC_DIV128 3'h4
`define TCPW_MASK_DIV1 11'h000
`define TCPW_MASK_DIV2 11'h001
`define TCPW_MASK_DIV8 11'h007
`define TCPW_MASK_DIV32 11'h01f
`define TCPW_MASK_DIV128 11'h07f
`define TCPW_MASK_DIV2048 11'h7ff

// Status register fields.
`define TCPW_ST_CNT_MSB 15
`define TCPW_ST_PIN3_BIT 16
`define TCPW_ST_PIN4_BIT 17

// ==========================================================================
// Timing: reference clock cycles per machine cycle, stable samples needed.
`define TCPW_MC_DIV 4
`define TCPW_EV_STABLE 2

// AHB-Lite codes.
`define TCPW_HRESP_OKAY 1'b0
`define TCPW_WORD_ZERO 32'h0000_0000

`endif

// File: tcpw_evsync.v
/*
  Event input qualifier: samples the external event pin once per machine
  cycle and reports a one-cycle pulse on each qualified falling edge.
  Assumes the pin is synchronous to ref_clk and ce gates all state.
*/
`include "tcpw_defines.vh"

module tcpw_evsync #(
  parameter MC_DIV = `TCPW_MC_DIV,
  parameter STABLE = `TCPW_EV_STABLE
) (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire event_in,
  output reg fall_q
);

  reg [7:0] mc_q;
  reg [7:0] run_q;
  reg samp_q;
  reg level_q;
  wire mc_tick;

  assign mc_tick = (mc_q == MC_DIV - 1);

  // ========================================================================
  // Machine cycle divider and level filter.
  // A level counts only once it has been seen on STABLE machine cycles in a
  // row, so glitches no longer than one machine cycle never reach the counter.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mc_q <= 8'h00;
      run_q <= 8'h00;
      samp_q <= 1'b1;
      level_q <= 1'b1;
      fall_q <= 1'b0;
    end
    else if (ce)
    begin
      fall_q <= 1'b0;
      mc_q <= mc_tick ? 8'h00 : mc_q + 8'h01;
      if (mc_tick)
      begin
        samp_q <= event_in;
        if (event_in != samp_q)
          run_q <= 8'h01;
        else if (run_q < STABLE)
          run_q <= run_q + 8'h01;
        if (event_in == samp_q && run_q + 8'h01 >= STABLE && level_q != event_in)
        begin
          level_q <= event_in;
          fall_q <= level_q & ~event_in;
        end
      end
    end
  end

endmodule

// File: tcpw_pwm8.v
/*
  One 8-bit counter with duty compare shift stage and output flip-flop.
  Assumes tick is a one-cycle source clock pulse and that the control
  write strobe carries the new run and initial-value bits.
*/
`include "tcpw_defines.vh"

module tcpw_pwm8 #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire tick,
  input wire pwm_en,
  input wire run,
  input wire ctl_wr,
  input wire new_run,
  input wire new_ffi,
  input wire duty_wr,
  input wire [W-1:0] duty_wdata,
  output reg [W-1:0] duty_shift_q,
  output reg [W-1:0] cnt_q,
  output reg pin_q,
  output reg irq_q
);

  localparam [W-1:0] CNT_MAX = {W{1'b1}};
  localparam [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};

  reg [W-1:0] pend_q;
  reg ff_q;
  reg [W-1:0] cnt_d;
  reg [W-1:0] pend_d;
  reg [W-1:0] shift_d;
  reg ff_d;
  reg irq_d;

  // ========================================================================
  // Next state.
  always @*
  begin
    cnt_d = cnt_q;
    pend_d = pend_q;
    ff_d = ff_q;
    irq_d = 1'b0;
    shift_d = duty_shift_q;
    // The compared stage is also the one read back, so software keeps seeing
    // the old duty until the pending write is transferred at overflow.
    if (duty_wr)
      pend_d = duty_wdata;
    if (!run)
      shift_d = pend_d;
    if (ctl_wr && !run)
    begin
      // A write while the timer is stopped loads the flip-flop from the initial-value bit.
      ff_d = new_ffi;
      cnt_d = {W{1'b0}};
    end
    else if (pwm_en && tick)
    begin
      if (cnt_q == duty_shift_q)
        ff_d = ~ff_d;
      if (cnt_q == CNT_MAX)
      begin
        ff_d = ~ff_d;
        cnt_d = {W{1'b0}};
        irq_d = 1'b1;
        shift_d = pend_d;
      end
      else
        cnt_d = cnt_q + CNT_ONE;
    end
  end

  // ========================================================================
  // State registers; the pin is registered from the next flip-flop level.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= {W{1'b0}};
      pend_q <= {W{1'b0}};
      duty_shift_q <= {W{1'b0}};
      ff_q <= 1'b0;
      pin_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      duty_shift_q <= shift_d;
      ff_q <= ff_d;
      pin_q <= ~ff_d;
      irq_q <= irq_d;
    end
  end

endmodule

// File: tcpw_top.v
/*
  Top of the cascadable timer / PWM / event counter: AHB-Lite register
  slave, source clock prescaler, two 8-bit PWM counters and the cascaded
  16-bit timer / event counter.
  Assumes one clock ref_clk, synchronous active-high rst, a clock enable
  that is held high while bus transfers are in flight, and an event pin
  synchronous to ref_clk.
*/
// What this block does
// - PWM8: count up; toggle output flip-flop when count equals duty compare.
// - PWM8 overflow: toggle again, clear counter, pulse that counter's match irq.
// - Flip-flop starts from initial-value bit; reset clears it to zero.
// - PWM pin is always the inverse of the output flip-flop.
// - Duty write waits in pending stage until overflow; loads at once if stopped.
// - Duty compare reads return the shift-stage value.
// - Stopping during PWM holds the pin at its level.
// - Control bit 3 is run, bit 7 initial value; clear 7 stopped gives pin high.
// - 16-bit timer: cascaded counters on source clock against both period bytes.
// - After counter 4 runs, a 16-bit match pulses cascade irq and clears.
// - Period registers are unbuffered and act at once.
// - Event mode: cascaded counter advances on each qualified falling edge.
// - Event mode match pulses cascade irq, clears, and resumes on edges.
// - Event phases need two machine cycles each to count.
`include "tcpw_defines.vh"

module tcpw_top #(
  parameter W = 8,
  parameter MC_DIV = `TCPW_MC_DIV
) (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire event_input_pin,
  output wire pwm_out_pin3,
  output wire pwm_out_pin4,
  output wire counter_match_irq3,
  output wire counter_match_irq4,
  output reg cascade_match_irq_q
);

  // ========================================================================
  // Register state.
  reg [7:0] ctrl3_q;
  reg [7:0] ctrl4_q;
  reg [W-1:0] period_reg_low_q;
  reg [W-1:0] period_reg_high_q;
  reg [2*W-1:0] cnt16_q;
  reg [10:0] presc_q;

  // Bus data phase tracking.
  reg wr_pend_q;
  reg [7:0] wr_addr_q;

  wire [W-1:0] duty3_shift;
  wire [W-1:0] duty4_shift;
  wire [W-1:0] cnt3;
  wire [W-1:0] cnt4;
  wire ev_fall;

  // ========================================================================
  // Source clock prescaler.
  // One free-running divider serves every channel; a select code picks the
  // tick rate by masking its low bits, so all rates stay phase-aligned.
  function [10:0] src_mask;
    input [2:0] sel;
    begin
      case (sel)
        `TCPW_SRC_DIV1: src_mask = `TCPW_MASK_DIV1;
        `TCPW_SRC_DIV2: src_mask = `TCPW_MASK_DIV2;
        `TCPW_SRC_DIV8: src_mask = `TCPW_MASK_DIV8;
        `TCPW_SRC_DIV32: src_mask = `TCPW_MASK_DIV32;
        `TCPW_SRC_DIV128: src_mask = `TCPW_MASK_DIV128;
        default: src_mask = `TCPW_MASK_DIV2048;
      endcase
    end
  endfunction

  wire [10:0] mask3;
  wire [10:0] mask4;
  wire tick3;
  wire tick4;

  assign mask3 = src_mask(ctrl3_q[`TCPW_SRC_MSB:`TCPW_SRC_LSB]);
  assign mask4 = src_mask(ctrl4_q[`TCPW_SRC_MSB:`TCPW_SRC_LSB]);
  assign tick3 = ((presc_q & mask3) == mask3);
  assign tick4 = ((presc_q & mask4) == mask4);

  always @(posedge ref_clk)
  begin
    if (rst)
      presc_q <= 11'h000;
    else if (ce)
      presc_q <= presc_q + 11'h001;
  end

  // ========================================================================
  // Mode decode.
  wire [1:0] mode3;
  wire [1:0] mode4;
  wire run3;
  wire run4;
  wire cas_tmr;
  wire cas_evt;
  wire cas_run;

  assign mode3 = ctrl3_q[`TCPW_MODE_MSB:`TCPW_MODE_LSB];
  assign mode4 = ctrl4_q[`TCPW_MODE_MSB:`TCPW_MODE_LSB];
  assign run3 = ctrl3_q[`TCPW_RUN_BIT];
  assign run4 = ctrl4_q[`TCPW_RUN_BIT];
  assign cas_tmr = (mode4 == `TCPW_MODE_TMR16);
  assign cas_evt = (mode4 == `TCPW_MODE_EVT16);
  // Counter 4 owns the cascade: its mode and run bit start the 16-bit counter.
  assign cas_run = (cas_tmr | cas_evt) & run4;

  // ========================================================================
  // AHB-Lite slave.
  // Zero wait states: the read word is registered in the address phase, so
  // it stands in the data phase; a write lands at the end of its data phase.
  wire addr_ok;
  wire rd_take;
  wire wr_ctrl3;
  wire wr_ctrl4;
  wire wr_duty3;
  wire wr_duty4;

  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_take = addr_ok & ~hwrite;
  assign wr_ctrl3 = wr_pend_q & (wr_addr_q == `TCPW_OFS_CTRL3);
  assign wr_ctrl4 = wr_pend_q & (wr_addr_q == `TCPW_OFS_CTRL4);
  assign wr_duty3 = wr_pend_q & (wr_addr_q == `TCPW_OFS_DUTY3);
  assign wr_duty4 = wr_pend_q & (wr_addr_q == `TCPW_OFS_DUTY4);

  reg [31:0] rd_word;
  always @*
  begin
    rd_word = `TCPW_WORD_ZERO;
    case (haddr[7:0])
      `TCPW_OFS_CTRL3: rd_word[7:0] = ctrl3_q;
      `TCPW_OFS_CTRL4: rd_word[7:0] = ctrl4_q;
      `TCPW_OFS_PER_LO: rd_word[W-1:0] = period_reg_low_q;
      `TCPW_OFS_PER_HI: rd_word[W-1:0] = period_reg_high_q;
      `TCPW_OFS_DUTY3: rd_word[W-1:0] = duty3_shift;
      `TCPW_OFS_DUTY4: rd_word[W-1:0] = duty4_shift;
      `TCPW_OFS_STATUS:
      begin
        if (cas_tmr | cas_evt)
          rd_word[`TCPW_ST_CNT_MSB:0] = cnt16_q;
        else
          rd_word[`TCPW_ST_CNT_MSB:0] = {cnt4, cnt3};
        rd_word[`TCPW_ST_PIN3_BIT] = pwm_out_pin3;
        rd_word[`TCPW_ST_PIN4_BIT] = pwm_out_pin4;
      end
      default: rd_word = `TCPW_WORD_ZERO;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= `TCPW_HRESP_OKAY;
      hrdata <= `TCPW_WORD_ZERO;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= `TCPW_HRESP_OKAY;
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_q <= haddr[7:0];
      if (rd_take)
        hrdata <= rd_word;
      else
        hrdata <= `TCPW_WORD_ZERO;
    end
  end

  // ========================================================================
  // Control and period registers.
  // Periods are plain registers: a new value is compared from the next cycle.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl3_q <= `TCPW_CTRL_RST;
      ctrl4_q <= `TCPW_CTRL_RST;
      period_reg_low_q <= `TCPW_BYTE_RST;
      period_reg_high_q <= `TCPW_BYTE_RST;
    end
    else if (ce && wr_pend_q)
    begin
      case (wr_addr_q)
        `TCPW_OFS_CTRL3: ctrl3_q <= hwdata[7:0];
        `TCPW_OFS_CTRL4: ctrl4_q <= hwdata[7:0];
        `TCPW_OFS_PER_LO: period_reg_low_q <= hwdata[W-1:0];
        `TCPW_OFS_PER_HI: period_reg_high_q <= hwdata[W-1:0];
        default: ctrl3_q <= ctrl3_q;
      endcase
    end
  end

  // ========================================================================
  // 8-bit PWM channels, one per counter.
  tcpw_pwm8 #(
    .W(W)
  ) u_ch3 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .tick(tick3),
    .pwm_en(run3 & (mode3 == `TCPW_MODE_PWM8)),
    .run(run3),
    .ctl_wr(wr_ctrl3),
    .new_run(hwdata[`TCPW_RUN_BIT]),
    .new_ffi(hwdata[`TCPW_FFI_BIT]),
    .duty_wr(wr_duty3),
    .duty_wdata(hwdata[W-1:0]),
    .duty_shift_q(duty3_shift),
    .cnt_q(cnt3),
    .pin_q(pwm_out_pin3),
    .irq_q(counter_match_irq3)
  );

  tcpw_pwm8 #(
    .W(W)
  ) u_ch4 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .tick(tick4),
    .pwm_en(run4 & (mode4 == `TCPW_MODE_PWM8)),
    .run(run4),
    .ctl_wr(wr_ctrl4),
    .new_run(hwdata[`TCPW_RUN_BIT]),
    .new_ffi(hwdata[`TCPW_FFI_BIT]),
    .duty_wr(wr_duty4),
    .duty_wdata(hwdata[W-1:0]),
    .duty_shift_q(duty4_shift),
    .cnt_q(cnt4),
    .pin_q(pwm_out_pin4),
    .irq_q(counter_match_irq4)
  );

  // ========================================================================
  // Event input qualifier.
  tcpw_evsync #(
    .MC_DIV(MC_DIV),
    .STABLE(`TCPW_EV_STABLE)
  ) u_ev (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .event_in(event_input_pin),
    .fall_q(ev_fall)
  );

  // ========================================================================
  // Cascaded 16-bit timer / event counter.
  // In timer mode the cascade counts on counter 3's source clock select. A stopped
  // cascade holds zero, so every start begins a full period.
  wire [2*W-1:0] period16;
  wire [2*W-1:0] cnt16_inc;
  wire cas_adv;

  assign period16 = {period_reg_high_q, period_reg_low_q};
  assign cnt16_inc = cnt16_q + {{(2*W-1){1'b0}}, 1'b1};
  assign cas_adv = cas_run & ((cas_tmr & tick3) | (cas_evt & ev_fall));

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt16_q <= {(2*W){1'b0}};
      cascade_match_irq_q <= 1'b0;
    end
    else if (ce)
    begin
      cascade_match_irq_q <= 1'b0;
      if (!cas_run)
        cnt16_q <= {(2*W){1'b0}};
      else if (cas_adv)
      begin
        if (cnt16_inc == period16)
        begin
          cnt16_q <= {(2*W){1'b0}};
          cascade_match_irq_q <= 1'b1;
        end
        else
          cnt16_q <= cnt16_inc;
      end
    end
  end

endmodule

// File: tcpw_assertions.sv
/*
  Port checker of the timer / PWM / event counter top, bound to it.
  Assumes ce stays high while bus transfers and counting are judged.
*/
module tcpw_assertions #(
  parameter W = 8,
  parameter MC_DIV = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire pwm_out_pin3,
  input wire pwm_out_pin4,
  input wire counter_match_irq3,
  input wire counter_match_irq4,
  input wire cascade_match_irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Reset state.
  AST_PIN_RST: assert property (disable iff (1'b0) rst |=> pwm_out_pin3 && pwm_out_pin4)
    else $error("pwm pins not high after reset");
  AST_IRQ_RST: assert property (disable iff (1'b0) rst |=>
    !counter_match_irq3 && !counter_match_irq4 && !cascade_match_irq_q)
    else $error("match pulse during reset");
  // ==========================================================================
  // Register bus answers.
  AST_OKAY: assert property (hsel && htrans[1] && hready && ce |=> hreadyout && !hresp)
    else $error("transfer not answered okay");
  AST_WR_ZERO: assert property (hsel && htrans[1] && hwrite && hready && ce |=> hrdata == 32'h0)
    else $error("read data during write");
  AST_RD_IDLE: assert property (hrdata != 32'h0 |->
    $past(hsel && htrans[1] && !hwrite && hready && ce))
    else $error("read data outside read data phase");
  // ==========================================================================
  // PWM period: each match pulse is followed by at least 8 quiet cycles.
  AST_IRQ3_GAP: assert property (counter_match_irq3 |=> !counter_match_irq3 [*8])
    else $error("channel 3 match pulses too close");
  AST_IRQ4_GAP: assert property (counter_match_irq4 |=> !counter_match_irq4 [*8])
    else $error("channel 4 match pulses too close");
  AST_PIN_IRQ3: assert property (counter_match_irq3 |=> $stable(pwm_out_pin3))
    else $error("channel 3 pin moved right after overflow");
endmodule

bind tcpw_top tcpw_assertions #(.W(W), .MC_DIV(MC_DIV)) chk_u (.ref_clk(ref_clk), .rst(rst),
  .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out_pin3(pwm_out_pin3),
  .pwm_out_pin4(pwm_out_pin4), .counter_match_irq3(counter_match_irq3),
  .counter_match_irq4(counter_match_irq4), .cascade_match_irq_q(cascade_match_irq_q));

// File: tcpw_evsrc.sv
/*
  External event pulse source for the event input pin.
  Assumes go is a one-cycle request and count and phase hold until busy falls.
*/
module tcpw_evsrc (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] n_pulse,
  input wire logic [7:0] phase,
  output logic ev,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Idle level is high, as a pulled-up line would rest.
  initial
  begin
    ev = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (go === 1'b1)
      begin
        busy <= 1'b1;
        repeat (n_pulse)
        begin
          ev <= 1'b0;
          repeat (phase) @(posedge ref_clk);
          ev <= 1'b1;
          repeat (phase) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: tb.sv
/*
  Self-checking bench of the timer / PWM / event counter top.
  Assumes the design files, the checker and the event source are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic [7:0] npul = 8'h0;
  logic [7:0] ph = 8'h0;
  logic [31:0] rs = 32'd1457;
  wire hreadyout, hresp, ev, busy, p3, p4, i3, i4, ic;
  wire [31:0] hrdata;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int casc_n = 0;
  int low [2] = '{0, 0};
  int last [2] = '{0, 0};

  always #2.5 ref_clk = ~ref_clk;

  tcpw_top dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_input_pin(ev),
    .pwm_out_pin3(p3), .pwm_out_pin4(p4), .counter_match_irq3(i3),
    .counter_match_irq4(i4), .cascade_match_irq_q(ic));
  tcpw_evsrc src_u (.ref_clk(ref_clk), .go(go), .n_pulse(npul), .phase(ph), .ev(ev),
    .busy(busy));

  // ==========================================================================
  // Monitor: low samples of each pin between match pulses, cascade pulse count.
  // The pin load stands for a port latch that software already set to one.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (ic === 1'b1) casc_n <= casc_n + 1;
    for (int c = 0; c < 2; c++)
      if ((c ? i4 : i3) === 1'b1)
      begin
        last[c] <= low[c];
        low[c] <= 0;
      end
      else if ((c ? p4 : p3) === 1'b0) low[c] <= low[c] + 1;
  end

  // ==========================================================================
  // Expectations and helpers.
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int low_exp(input int d);
    return 255 - d;
  endfunction
  function automatic int gap(input int n, input int s);
    return n * (s == 0 ? 1 : s == 1 ? 2 : 8);
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask
  task automatic pinc(input int c, input logic e);
    repeat (3) @(posedge ref_clk);
    chk(c ? "pin4" : "pin3", e, c ? p4 : p3);
  endtask
  task automatic wt(input int s, output int t);
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while ((s == 0 ? i3 : s == 1 ? i4 : ic) !== 1'b1 && k < 3000);
    if (k >= 3000) chk("wait", 1, 0);
    t = cyc;
  endtask
  task automatic pulse(input int n, input int w);
    int k;
    npul <= 8'(n);
    ph <= 8'(w);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (busy !== 1'b0 && k < 2000);
    repeat (24) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // Watchdog, far beyond the few thousand cycles the tests need.
  initial
  begin
    #200000;
    n_mismatch++;
    test_done;
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    int d1, d2, t0, t1, n, s, p;
    logic [7:0] co, cd;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("pin3", 1, p3);
    chk("pin4", 1, p4);
    wr(8'h1c, 32'hff);
    rdc("hole", 8'h1c, 0);
    for (int c = 0; c < 2; c++)
    begin
      co = 8'(4 * c);
      cd = 8'(8'h10 + 4 * c);
      rs = xs(rs);
      d1 = c ? 2 + rs % 253 : 2;
      rs = xs(rs);
      d2 = c ? 2 + rs % 253 : 254;
      wr(co, 32'h81);
      pinc(c, 1'b0);
      wr(co, 32'h01);
      pinc(c, 1'b1);
      wr(cd, d1);
      rdc("duty", cd, d1);
      wr(co, 32'h09);
      wt(c, t0);
      wt(c, t1);
      chk("period", 256, t1 - t0);
      wr(cd, d2);
      rdc("duty_rd", cd, d1);
      wt(c, t0);
      @(posedge ref_clk);
      chk("low_old", low_exp(d1), last[c]);
      rdc("duty_new", cd, d2);
      wt(c, t0);
      @(posedge ref_clk);
      chk("low_new", low_exp(d2), last[c]);
      repeat (d2 + (255 - d2) / 2) @(posedge ref_clk);
      wr(co, 32'h01);
      repeat (2) @(posedge ref_clk);
      p = c ? p4 : p3;
      repeat (40) @(posedge ref_clk);
      chk("pin_hold", p, c ? p4 : p3);
      wr(co, 32'h81);
      pinc(c, 1'b0);
      wr(co, 32'h01);
      pinc(c, 1'b1);
    end
    rs = xs(rs);
    s = rs % 3;
    n = 20 + (rs >> 8) % 40;
    wr(8'h00, s << 4);
    wr(8'h08, n);
    wr(8'h0c, 0);
    wr(8'h04, 32'h0a);
    wt(2, t0);
    wt(2, t1);
    chk("tmr_gap", gap(n, s), t1 - t0);
    wr(8'h08, n + 7);
    wr(8'h0c, 0);
    wt(2, t0);
    chk("tmr_new", gap(n + 7, s), t0 - t1);
    // A frozen clock enable stretches the period by exactly the frozen cycles.
    ce <= 1'b0;
    repeat (37) @(posedge ref_clk);
    ce <= 1'b1;
    wt(2, t1);
    chk("ce_hold", gap(n + 7, s) + 37, t1 - t0);
    wr(8'h04, 0);
    wr(8'h08, 3);
    wr(8'h0c, 0);
    wr(8'h04, 32'h0b);
    p = casc_n;
    pulse(7, 12);
    chk("evt_irqs", 2, casc_n - p);
    rdc("evt_cnt", 8'h18, 32'h0003_0001);
    pulse(1, 3);
    pulse(1, 3);
    rdc("evt_short", 8'h18, 32'h0003_0001);
    test_done;
  end
endmodule
